// File: rtl/pti_pkg.sv
// Constants, register map and field layout of the pattern input and trigger block
// Function
// - Video mode passes 30-bit pixel words
// - Pattern mode keeps top 8 bits per colour
// - Input word width selectable: 24, 27, 30
// - Pixel inputs sampled on source pixel clock
// - Colour channel groups swappable by configuration
// - Source keeps syncs periodic; stills fit frame
// - Repeat last frame at source rate
// - Three light channels, each with enable
// - Per-channel PWM duty sets light current
// - Alive output toggles only while healthy
// - Fault output off during system fault
// - First trigger advances or alternates patterns
// - Second trigger pauses or advances two
// - Exposure marker high during exposure only
// - First-pattern marker high on sequence start
package pti_pkg;
  localparam int CLK_HZ      = 100_000_000;
  localparam int HB_HALF_MS  = 250;
  localparam int HB_HALF_CYC = (CLK_HZ / 1000) * HB_HALF_MS;
  localparam int HB_W        = 25;
  localparam int CH_W        = 10;
  localparam int NCH         = 3;
  localparam int PIX_W       = CH_W * NCH;
  localparam int PAT_BITS    = 8;
  localparam int W24_BITS    = 8;
  localparam int W27_BITS    = 9;
  localparam int PER_W       = 24;
  localparam int EXP_W       = 16;
  localparam int IDX_W       = 8;
  localparam int DUTY_W      = 8;
  localparam int ST_W        = 5;
  localparam int CTRL_W      = 12;
  localparam int ADDR_W      = 8;

  // Byte addresses
  localparam logic [ADDR_W-1:0] A_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] A_DUTY  = 8'h04;
  localparam logic [ADDR_W-1:0] A_EXP   = 8'h08;
  localparam logic [ADDR_W-1:0] A_PCNT  = 8'h0c;
  localparam logic [ADDR_W-1:0] A_STS   = 8'h10;
  localparam logic [ADDR_W-1:0] A_MASK  = 8'h14;
  localparam logic [ADDR_W-1:0] A_PIXEL = 8'h18;
  localparam logic [ADDR_W-1:0] A_STATE = 8'h1c;

  // Control and duty fields
  localparam int C_MODE   = 0;
  localparam int C_WID_LO = 1;
  localparam int C_SWP_LO = 3;
  localparam int C_T1ALT  = 6;
  localparam int C_T2TWO  = 7;
  localparam int C_LEN_LO = 8;
  localparam int C_FLT    = 11;
  localparam int D_G_LO   = 8;
  localparam int D_B_LO   = 16;

  localparam logic [1:0] WID_24  = 2'h0;
  localparam logic [1:0] WID_27  = 2'h1;
  localparam logic [1:0] WID_BAD = 2'h3;
  localparam logic [2:0] SWP_ACB = 3'h1;
  localparam logic [2:0] SWP_BAC = 3'h2;
  localparam logic [2:0] SWP_BCA = 3'h3;
  localparam logic [2:0] SWP_CAB = 3'h4;
  localparam logic [2:0] SWP_CBA = 3'h5;

  // Status bits
  localparam int S_FRAME  = 0;
  localparam int S_REPEAT = 1;
  localparam int S_TRIG1  = 2;
  localparam int S_TRIG2  = 3;
  localparam int S_FAULT  = 4;

  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h004;
  localparam logic [EXP_W-1:0]  EXP_RST  = 16'h0064;
  localparam logic [IDX_W-1:0]  PCNT_RST = 8'h02;

  typedef enum logic [1:0] {
    EXP_IDLE = 2'b01,
    EXP_ON   = 2'b10
  } pti_exp_e;

  function automatic logic [CH_W-1:0] pti_chan_mask(input int keep);
    pti_chan_mask = ~((CH_W'(1) << (CH_W - keep)) - CH_W'(1));
  endfunction
endpackage

// File: rtl/pti_sync2.sv
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module pti_sync2 #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// File: rtl/pti_pwm.sv
// One light-current PWM channel with a free-running period counter
`timescale 1ns/1ps
module pti_pwm import pti_pkg::*; #(
  parameter int W = DUTY_W
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic         en,
  input  wire logic [W-1:0] duty,
  output logic              pwm
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_pwm;

  always_comb begin
    next_cnt = cnt + W'(1);
    next_pwm = en && (cnt < duty);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      pwm <= 1'b0;
    end else if (ce) begin
      cnt <= next_cnt;
      pwm <= next_pwm;
    end
  end

  a_pwm_duty_high: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && en && (cnt < duty) |=> pwm) else $error("pwm low inside duty window");
  a_pwm_off_low: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (!en || cnt >= duty) |=> !pwm) else $error("pwm high outside duty window");
endmodule

// File: rtl/pti_top.sv
// Pixel input capture, pattern triggers, illumination and indicators with AHB-Lite registers
`timescale 1ns/1ps
module pti_top import pti_pkg::*; #(
  parameter int HB_HALF = HB_HALF_CYC
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             pixel_clock_in,
  input  wire logic             frame_sync_in,
  input  wire logic             line_sync_in,
  input  wire logic             pixel_valid_in,
  input  wire logic [PIX_W-1:0] rgb_pixel_bus,
  input  wire logic             advance_trigger_in,
  input  wire logic             pause_trigger_in,
  output logic      [PIX_W-1:0] pixel_word_out,
  output logic                  pixel_word_valid,
  output logic                  frame_start_out,
  output logic                  line_start_out,
  output logic                  red_light_enable,
  output logic                  green_light_enable,
  output logic                  blue_light_enable,
  output logic                  red_current_pwm,
  output logic                  green_current_pwm,
  output logic                  blue_current_pwm,
  output logic                  alive_blink_out,
  output logic                  fault_ok_out,
  output logic                  exposure_marker_out,
  output logic                  first_pattern_marker_out,
  output logic                  irq
);
  // Synchronised inputs
  logic [PIX_W+3:0] pix_s;
  logic [1:0]       trig_s;
  logic             s_pclk;
  logic             s_vs;
  logic             s_hs;
  logic             s_de;
  logic [PIX_W-1:0] s_rgb;

  // Pixel capture state
  logic             pclk_q;
  logic             vs_q;
  logic             hs_q;
  logic             pix_edge;
  logic             next_pclk;
  logic             next_vs;
  logic             next_hs;
  logic [PIX_W-1:0] next_word;
  logic             next_valid;
  logic             next_fs;
  logic             next_ls;

  // Frame period tracking
  logic [PER_W-1:0] per_cnt;
  logic [PER_W-1:0] per_len;
  logic             repeat_q;
  logic [PER_W-1:0] next_per_cnt;
  logic [PER_W-1:0] next_per_len;
  logic             next_rep;
  logic             refresh;

  // Pattern and exposure state
  logic [1:0]       t_q;
  logic             t1_rise;
  logic             t2_rise;
  logic             paused;
  logic [IDX_W-1:0] pat_idx;
  logic [EXP_W-1:0] exp_cnt;
  pti_exp_e         exp_state;
  logic [1:0]       next_t_q;
  logic [IDX_W-1:0] next_idx;
  logic [EXP_W-1:0] next_exp_cnt;
  pti_exp_e         next_state;
  logic             next_expose;
  logic             next_first;

  // Indicators and lights
  logic             fault;
  logic [HB_W-1:0]  hb_cnt;
  logic [HB_W-1:0]  next_hb_cnt;
  logic             next_blink;
  logic [NCH-1:0]   next_len;

  // Bus and registers
  logic              wr_pend;
  logic              rd_pend;
  logic [ADDR_W-1:0] addr_q;
  logic              addr_ph;
  logic              next_wr;
  logic              next_rd;
  logic [ADDR_W-1:0] next_addr;
  logic              next_ready;
  logic [31:0]       next_rdata;
  logic [31:0]       rd_mux;
  logic [CTRL_W-1:0] ctrl;
  logic [DUTY_W-1:0] duty_r;
  logic [DUTY_W-1:0] duty_g;
  logic [DUTY_W-1:0] duty_b;
  logic [EXP_W-1:0]  exp_len;
  logic [IDX_W-1:0]  pat_cnt;
  logic [ST_W-1:0]   sts;
  logic [ST_W-1:0]   mask;
  logic [ST_W-1:0]   ev;
  logic [CTRL_W-1:0] next_ctrl;
  logic [DUTY_W-1:0] next_dr;
  logic [DUTY_W-1:0] next_dg;
  logic [DUTY_W-1:0] next_db;
  logic [EXP_W-1:0]  next_exp_len;
  logic [IDX_W-1:0]  next_pat_cnt;
  logic [ST_W-1:0]   next_sts;
  logic [ST_W-1:0]   next_mask;
  logic              next_irq;

  // Word is {C, B, A}; A in the low ten bits
  function automatic logic [PIX_W-1:0] swap_ch(input logic [PIX_W-1:0] w, input logic [2:0] sel);
    logic [CH_W-1:0] a;
    logic [CH_W-1:0] b;
    logic [CH_W-1:0] c;
    a = w[CH_W-1:0];
    b = w[2*CH_W-1:CH_W];
    c = w[PIX_W-1:2*CH_W];
    case (sel)
      SWP_ACB: swap_ch = {b, c, a};
      SWP_BAC: swap_ch = {c, a, b};
      SWP_BCA: swap_ch = {a, c, b};
      SWP_CAB: swap_ch = {b, a, c};
      SWP_CBA: swap_ch = {a, b, c};
      default: swap_ch = w;
    endcase
  endfunction

  // Narrow widths drop low lines, where narrow sources leave nothing
  function automatic logic [PIX_W-1:0] word_mask(input logic pat, input logic [1:0] wid);
    logic [CH_W-1:0] m;
    if (pat) begin
      m = pti_chan_mask(PAT_BITS);
    end else begin
      case (wid)
        WID_24:  m = pti_chan_mask(W24_BITS);
        WID_27:  m = pti_chan_mask(W27_BITS);
        default: m = pti_chan_mask(CH_W);
      endcase
    end
    word_mask = {NCH{m}};
  endfunction

  function automatic logic [IDX_W-1:0] step_idx(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] cnt,
                                                input logic [1:0] step);
    logic [IDX_W:0] s;
    logic [IDX_W:0] n;
    n = (cnt == '0) ? (IDX_W+1)'(1) : {1'b0, cnt};
    s = {1'b0, idx} + {{(IDX_W-1){1'b0}}, step};
    if (s >= n) s = s - n;
    if (s >= n) s = s - n;
    step_idx = s[IDX_W-1:0];
  endfunction

  pti_sync2 #(.W(PIX_W+4)) u_pix_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       ({pixel_clock_in, frame_sync_in, line_sync_in, pixel_valid_in, rgb_pixel_bus}),
    .q       (pix_s)
  );

  pti_sync2 #(.W(2)) u_trig_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       ({pause_trigger_in, advance_trigger_in}),
    .q       (trig_s)
  );

  assign s_pclk = pix_s[PIX_W+3];
  assign s_vs   = pix_s[PIX_W+2];
  assign s_hs   = pix_s[PIX_W+1];
  assign s_de   = pix_s[PIX_W];
  assign s_rgb  = pix_s[PIX_W-1:0];

  // Pixel capture on the sampled rising edge of the source pixel clock
  assign pix_edge = s_pclk & ~pclk_q;
  always_comb begin
    next_pclk  = s_pclk;
    next_vs    = vs_q;
    next_hs    = hs_q;
    next_word  = pixel_word_out;
    next_valid = 1'b0;
    next_fs    = 1'b0;
    next_ls    = 1'b0;
    if (pix_edge) begin
      next_vs = s_vs;
      next_hs = s_hs;
      next_fs = s_vs & ~vs_q;
      next_ls = s_hs & ~hs_q;
      if (s_de) begin
        next_word  = swap_ch(s_rgb, ctrl[C_SWP_LO+:3]) & word_mask(ctrl[C_MODE], ctrl[C_WID_LO+:2]);
        next_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pclk_q           <= 1'b0;
      vs_q             <= 1'b0;
      hs_q             <= 1'b0;
      pixel_word_out   <= '0;
      pixel_word_valid <= 1'b0;
      frame_start_out  <= 1'b0;
      line_start_out   <= 1'b0;
    end else if (ce) begin
      pclk_q           <= next_pclk;
      vs_q             <= next_vs;
      hs_q             <= next_hs;
      pixel_word_out   <= next_word;
      pixel_word_valid <= next_valid;
      frame_start_out  <= next_fs;
      line_start_out   <= next_ls;
    end
  end

  // Frame period; a missed frame is replaced by a repeat tick
  always_comb begin
    next_per_cnt = (per_cnt == '1) ? per_cnt : per_cnt + PER_W'(1);
    next_per_len = per_len;
    next_rep     = 1'b0;
    if (frame_start_out) begin
      next_per_len = next_per_cnt;
      next_per_cnt = '0;
    end else if (per_len != '0 && per_cnt == per_len - PER_W'(1)) begin
      next_rep     = 1'b1;
      next_per_cnt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt  <= '0;
      per_len  <= '0;
      repeat_q <= 1'b0;
    end else if (ce) begin
      per_cnt  <= next_per_cnt;
      per_len  <= next_per_len;
      repeat_q <= next_rep;
    end
  end

  assign refresh = frame_start_out | repeat_q;

  // Triggers, pattern index and exposure
  assign t1_rise = trig_s[0] & ~t_q[0];
  assign t2_rise = trig_s[1] & ~t_q[1];
  assign paused  = ~ctrl[C_T2TWO] & trig_s[1];
  assign fault   = ctrl[C_FLT] | (ctrl[C_WID_LO+:2] == WID_BAD);

  always_comb begin
    next_t_q     = trig_s;
    next_idx     = pat_idx;
    next_state   = exp_state;
    next_exp_cnt = exp_cnt;
    next_first   = first_pattern_marker_out;
    if (t1_rise) begin
      if (ctrl[C_T1ALT]) begin
        next_idx = (pat_idx == '0) ? IDX_W'(1) : '0;
      end else begin
        next_idx = step_idx(pat_idx, pat_cnt, 2'd1);
      end
    end else if (t2_rise && ctrl[C_T2TWO]) begin
      next_idx = step_idx(pat_idx, pat_cnt, 2'd2);
    end
    case (exp_state)
      EXP_IDLE: begin
        if (refresh && !paused && !fault && exp_len != '0) begin
          next_state   = EXP_ON;
          next_exp_cnt = exp_len - EXP_W'(1);
          next_first   = (pat_idx == '0);
        end
      end
      EXP_ON: begin
        if (exp_cnt == '0) begin
          next_state = EXP_IDLE;
          next_first = 1'b0;
        end else begin
          next_exp_cnt = exp_cnt - EXP_W'(1);
        end
      end
      default: begin
        next_state = EXP_IDLE;
        next_first = 1'b0;
      end
    endcase
    next_expose = (next_state == EXP_ON);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t_q                      <= '0;
      pat_idx                  <= '0;
      exp_state                <= EXP_IDLE;
      exp_cnt                  <= '0;
      exposure_marker_out      <= 1'b0;
      first_pattern_marker_out <= 1'b0;
    end else if (ce) begin
      t_q                      <= next_t_q;
      pat_idx                  <= next_idx;
      exp_state                <= next_state;
      exp_cnt                  <= next_exp_cnt;
      exposure_marker_out      <= next_expose;
      first_pattern_marker_out <= next_first;
    end
  end

  // Alive_blink_out and lights; a fault freezes the blink and drops enables
  always_comb begin
    next_hb_cnt = hb_cnt;
    next_blink  = alive_blink_out;
    if (!fault) begin
      if (hb_cnt >= HB_W'(HB_HALF - 1)) begin
        next_hb_cnt = '0;
        next_blink  = ~alive_blink_out;
      end else begin
        next_hb_cnt = hb_cnt + HB_W'(1);
      end
    end
    next_len = ctrl[C_LEN_LO+:NCH] & {NCH{~fault}};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hb_cnt             <= '0;
      alive_blink_out    <= 1'b0;
      fault_ok_out       <= 1'b0;
      red_light_enable   <= 1'b0;
      green_light_enable <= 1'b0;
      blue_light_enable  <= 1'b0;
    end else if (ce) begin
      hb_cnt             <= next_hb_cnt;
      alive_blink_out    <= next_blink;
      fault_ok_out       <= ~fault;
      red_light_enable   <= next_len[0];
      green_light_enable <= next_len[1];
      blue_light_enable  <= next_len[2];
    end
  end

  pti_pwm u_pwm_r (.hclk(hclk), .hresetn(hresetn), .ce(ce), .en(red_light_enable), .duty(duty_r),
                   .pwm(red_current_pwm));
  pti_pwm u_pwm_g (.hclk(hclk), .hresetn(hresetn), .ce(ce), .en(green_light_enable), .duty(duty_g),
                   .pwm(green_current_pwm));
  pti_pwm u_pwm_b (.hclk(hclk), .hresetn(hresetn), .ce(ce), .en(blue_light_enable), .duty(duty_b),
                   .pwm(blue_current_pwm));

  // AHB-Lite slave; reads take one wait state so hrdata leaves a flop
  always_comb begin
    ev           = '0;
    ev[S_FRAME]  = frame_start_out;
    ev[S_REPEAT] = repeat_q;
    ev[S_TRIG1]  = t1_rise;
    ev[S_TRIG2]  = t2_rise;
    ev[S_FAULT]  = fault;
    case (addr_q)
      A_CTRL:  rd_mux = {{(32-CTRL_W){1'b0}}, ctrl};
      A_DUTY:  rd_mux = {8'h00, duty_b, duty_g, duty_r};
      A_EXP:   rd_mux = {{(32-EXP_W){1'b0}}, exp_len};
      A_PCNT:  rd_mux = {{(32-IDX_W){1'b0}}, pat_cnt};
      A_STS:   rd_mux = {{(32-ST_W){1'b0}}, sts};
      A_MASK:  rd_mux = {{(32-ST_W){1'b0}}, mask};
      A_PIXEL: rd_mux = {{(32-PIX_W){1'b0}}, pixel_word_out};
      A_STATE: rd_mux = {{(32-IDX_W-3){1'b0}}, fault, paused, exposure_marker_out, pat_idx};
      default: rd_mux = '0;
    endcase
    addr_ph    = hsel & hready & htrans[1];
    next_wr    = addr_ph & hwrite;
    next_rd    = addr_ph & ~hwrite;
    next_addr  = addr_ph ? haddr[ADDR_W-1:0] : addr_q;
    next_ready = ~next_rd;
    next_rdata = rd_pend ? rd_mux : hrdata;
    next_ctrl    = ctrl;
    next_dr      = duty_r;
    next_dg      = duty_g;
    next_db      = duty_b;
    next_exp_len = exp_len;
    next_pat_cnt = pat_cnt;
    next_mask    = mask;
    next_sts     = sts | ev;
    if (wr_pend) begin
      case (addr_q)
        A_CTRL:  next_ctrl = hwdata[CTRL_W-1:0];
        A_DUTY: begin
          next_dr = hwdata[DUTY_W-1:0];
          next_dg = hwdata[D_G_LO+:DUTY_W];
          next_db = hwdata[D_B_LO+:DUTY_W];
        end
        A_EXP:   next_exp_len = hwdata[EXP_W-1:0];
        A_PCNT:  next_pat_cnt = hwdata[IDX_W-1:0];
        A_STS:   next_sts = (sts & ~hwdata[ST_W-1:0]) | ev;
        A_MASK:  next_mask = hwdata[ST_W-1:0];
        default: next_mask = mask;
      endcase
    end
    next_irq = |(next_sts & next_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      addr_q    <= '0;
      hreadyout <= 1'b1;
      hrdata    <= '0;
      hresp     <= 1'b0;
      ctrl      <= CTRL_RST;
      duty_r    <= '0;
      duty_g    <= '0;
      duty_b    <= '0;
      exp_len   <= EXP_RST;
      pat_cnt   <= PCNT_RST;
      sts       <= '0;
      mask      <= '0;
      irq       <= 1'b0;
    end else if (ce) begin
      wr_pend   <= next_wr;
      rd_pend   <= next_rd;
      addr_q    <= next_addr;
      hreadyout <= next_ready;
      hrdata    <= next_rdata;
      hresp     <= 1'b0;
      ctrl      <= next_ctrl;
      duty_r    <= next_dr;
      duty_g    <= next_dg;
      duty_b    <= next_db;
      exp_len   <= next_exp_len;
      pat_cnt   <= next_pat_cnt;
      sts       <= next_sts;
      mask      <= next_mask;
      irq       <= next_irq;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_video_word_full: assert property ($past(ce && pix_edge && s_de && !ctrl[C_MODE] && ctrl[C_SWP_LO+:3] == '0
    && ctrl[C_WID_LO+:2] == 2'h2) |-> pixel_word_out == $past(s_rgb)) else $error("video word altered");
  a_pattern_low_bits: assert property ($past(ce && pix_edge && s_de && ctrl[C_MODE]) |->
    (pixel_word_out & ~word_mask(1'b1, WID_24)) == '0) else $error("pattern low bits not dropped");
  a_capture_valid: assert property (pixel_word_valid |-> $past(pix_edge && s_de))
    else $error("word captured without data valid");
  a_swap_acb: assert property ($past(ce && pix_edge && s_de && !ctrl[C_MODE] && ctrl[C_SWP_LO+:3] == SWP_ACB
    && ctrl[C_WID_LO+:2] == 2'h2) |-> pixel_word_out[PIX_W-1:2*CH_W] == $past(s_rgb[2*CH_W-1:CH_W]))
    else $error("channel swap wrong");
  a_alt_toggle: assert property (ce && t1_rise && ctrl[C_T1ALT] |=>
    pat_idx <= IDX_W'(1) && pat_idx != $past(pat_idx)) else $error("alternate trigger did not toggle");
  a_pause_hold: assert property (ce && paused && exp_state == EXP_IDLE |=> !exposure_marker_out)
    else $error("exposure started while paused");
  a_expose_start: assert property (ce && refresh && exp_state == EXP_IDLE && !paused && !fault
    && exp_len != '0 |=> exposure_marker_out) else $error("exposure did not start");
  a_first_in_expose: assert property (first_pattern_marker_out |-> exposure_marker_out)
    else $error("first marker outside exposure");
  a_fault_led: assert property (ce && fault |=> !fault_ok_out && !red_light_enable)
    else $error("fault not shown");
  a_blink_frozen: assert property (ce && fault |=> $stable(alive_blink_out))
    else $error("alive blink toggled during fault");
  a_repeat_tick: assert property (ce && !frame_start_out && per_len != '0
    && per_cnt == per_len - PER_W'(1) |=> repeat_q) else $error("missing repeat tick");

  c_pattern_capture: cover property (pixel_word_valid && ctrl[C_MODE]);
  c_repeat_expose: cover property (repeat_q ##1 exposure_marker_out);
  c_first_pattern: cover property ($rose(first_pattern_marker_out));
  c_irq_raised: cover property ($rose(irq));
endmodule

// File: tb/pti_src_model.sv
// Behavioural pixel source driving the parallel pixel port
`timescale 1ns/1ps
module pti_src_model import pti_pkg::*; (
  output logic             pixel_clock_in,
  output logic             frame_sync_in,
  output logic             line_sync_in,
  output logic             pixel_valid_in,
  output logic [PIX_W-1:0] rgb_pixel_bus
);
  initial {pixel_clock_in, frame_sync_in, line_sync_in, pixel_valid_in, rgb_pixel_bus} = '0;

  // Clock stands still between words; offset keeps pin edges off the system clock edges
  task automatic send(input logic [PIX_W-1:0] w, input logic fs, input logic vld);
    #3;
    {frame_sync_in, line_sync_in, pixel_valid_in, rgb_pixel_bus} = {fs, 1'h1, vld, w};
    #80 pixel_clock_in = 1'h1;
    #80 pixel_clock_in = 1'h0;
    // Released bus shows the inverse, not a held value
    {frame_sync_in, line_sync_in, pixel_valid_in, rgb_pixel_bus} = {3'h0, ~w};
    #80;
  endtask
endmodule

// File: tb/pti_top_bench.sv
// Self-checking bench: registers, pixel capture, triggers, lights and indicators
`timescale 1ns/1ps
module pti_top_bench;
  import pti_pkg::*;
  localparam logic [9:0] CA = 10'h1f7, CB = 10'h2c3, CC = 10'h15a, M8 = 10'h3fc, M9 = 10'h3fe;
  logic             hclk, hresetn, hwrite, hreadyout, hresp, advance_trigger_in, pause_trigger_in;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0]       htrans;
  logic             pixel_clock_in, frame_sync_in, line_sync_in, pixel_valid_in, pixel_word_valid;
  logic [PIX_W-1:0] rgb_pixel_bus, pixel_word_out;
  logic             frame_start_out, line_start_out, red_light_enable, green_light_enable, blue_light_enable;
  logic             red_current_pwm, green_current_pwm, blue_current_pwm, alive_blink_out, fault_ok_out;
  logic             exposure_marker_out, first_pattern_marker_out, irq, b;
  int               fails, checked, vcnt, fcnt, exp_cnt, first_cnt, n;

  pti_top #(.HB_HALF(20)) dut (
    .hclk, .hresetn, .ce(1'h1), .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .pixel_clock_in, .frame_sync_in, .line_sync_in, .pixel_valid_in, .rgb_pixel_bus,
    .advance_trigger_in, .pause_trigger_in, .pixel_word_out, .pixel_word_valid, .frame_start_out, .line_start_out,
    .red_light_enable, .green_light_enable, .blue_light_enable, .red_current_pwm, .green_current_pwm,
    .blue_current_pwm, .alive_blink_out, .fault_ok_out, .exposure_marker_out, .first_pattern_marker_out, .irq);
  pti_src_model src (.pixel_clock_in, .frame_sync_in, .line_sync_in, .pixel_valid_in, .rgb_pixel_bus);

  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    vcnt += (pixel_word_valid === 1'h1);
    fcnt += (frame_start_out === 1'h1);
    exp_cnt += (exposure_marker_out === 1'h1);
    first_cnt += (first_pattern_marker_out === 1'h1);
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wt;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'h1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic pix(input logic [11:0] c, input logic vld, input logic [PIX_W-1:0] exp);
    wr(A_CTRL, {20'h0_0000, c});
    src.send({CC, CB, CA}, 1'h0, vld);
    @(posedge hclk);
    chk("pixel word", exp, pixel_word_out);
  endtask
  task automatic trig(input logic [11:0] c, input logic [31:0] exp);
    wr(A_CTRL, {20'h0_0000, c});
    advance_trigger_in <= !c[7];
    pause_trigger_in <= c[7] | pause_trigger_in;
    repeat (6) @(posedge hclk);
    advance_trigger_in <= 1'h0;
    pause_trigger_in <= pause_trigger_in & !c[7];
    repeat (6) @(posedge hclk);
    rchk("state", A_STATE, exp);
  endtask

  task automatic t_regs;
    rchk("ctrl", A_CTRL, 32'h4);
    rchk("exp", A_EXP, 32'h64);
    rchk("pcnt", A_PCNT, 32'h2);
    wr(A_DUTY, 32'h0080_2040);
    rchk("duty", A_DUTY, 32'h0080_2040);
    wr(A_PIXEL, 32'h1234_5678);
    rchk("pixel ro", A_PIXEL, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    chk("hresp", 32'h0, hresp);
    $display("test regs done");
  endtask
  task automatic t_pix;
    pix(12'h004, 1'h1, {CC, CB, CA});
    pix(12'h005, 1'h1, {CC & M8, CB & M8, CA & M8});
    pix(12'h002, 1'h1, {CC & M9, CB & M9, CA & M9});
    pix(12'h000, 1'h1, {CC & M8, CB & M8, CA & M8});
    pix(12'h00c, 1'h1, {CB, CC, CA});
    pix(12'h014, 1'h1, {CC, CA, CB});
    pix(12'h02c, 1'h1, {CA, CB, CC});
    pix(12'h004, 1'h0, {CA, CB, CC});
    chk("valid pulses", 32'h7, vcnt);
    $display("test pixel done");
  endtask
  task automatic t_trig;
    wr(A_EXP, 32'h14);
    wr(A_MASK, 32'h1);
    wr(A_STS, 32'h1f);
    {fcnt, exp_cnt, first_cnt} = '0;
    src.send({CC, CB, CA}, 1'h1, 1'h1);
    repeat (30) @(posedge hclk);
    chk("frame start", 32'h1, fcnt);
    chk("exposure", 32'h14, exp_cnt);
    chk("first marker", 32'h14, first_cnt);
    chk("irq set", 32'h1, irq);
    wr(A_STS, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq clear", 32'h0, irq);
    trig(12'h004, 32'h1);
    trig(12'h044, 32'h0);
    wr(A_PCNT, 32'h5);
    trig(12'h084, 32'h2);
    pause_trigger_in <= 1'h1;
    trig(12'h004, 32'h203);
    $display("test trigger done");
  endtask
  task automatic t_lite;
    wr(A_CTRL, 32'h704);
    repeat (2) @(posedge hclk);
    n = 0;
    repeat (256) begin
      @(posedge hclk);
      n += (red_current_pwm === 1'h1);
    end
    chk("red pwm", 32'h40, n);
    chk("enables", 32'h7, {red_light_enable, green_light_enable, blue_light_enable});
    b = alive_blink_out;
    repeat (20) @(posedge hclk);
    chk("blink", !b, alive_blink_out);
    wr(A_CTRL, 32'hf04);
    repeat (2) @(posedge hclk);
    chk("fault", 32'h0, fault_ok_out);
    chk("enables off", 32'h0, {red_light_enable, green_light_enable, blue_light_enable});
    b = alive_blink_out;
    repeat (45) @(posedge hclk);
    chk("blink frozen", b, alive_blink_out);
    wr(A_CTRL, 32'h4);
    repeat (2) @(posedge hclk);
    chk("healthy", 32'h1, fault_ok_out);
    $display("test lights done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {hresetn, htrans, hwrite, haddr, hwdata, advance_trigger_in, pause_trigger_in} = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs();
    t_pix();
    t_trig();
    t_lite();
    final_report();
  end
  // Whole run is some 700 cycles
  initial begin
    #100_000;
    fails++;
    final_report();
  end
endmodule
